// ===== logic/pew_defs.svh
`ifndef PEW_DEFS_SVH
`define PEW_DEFS_SVH
`define PEW_CLK_HZ        40000000
`define PEW_CLK_NS        25
`define PEW_STROBE_LOW_NS 100
`define PEW_STROBE_LOW_CYC ((`PEW_STROBE_LOW_NS + `PEW_CLK_NS - 1) / `PEW_CLK_NS)
`define PEW_READ_NS       150
`define PEW_READ_CYC      ((`PEW_READ_NS + `PEW_CLK_NS - 1) / `PEW_CLK_NS)
`define PEW_GAP_NS        100
`define PEW_GAP_CYC       ((`PEW_GAP_NS + `PEW_CLK_NS - 1) / `PEW_CLK_NS)
`define PEW_WINDOW_US     100
`define PEW_WINDOW_CYC    (`PEW_WINDOW_US * 40)
`define PEW_WRITE_MS      5
`define PEW_WRITE_CYC     (`PEW_WRITE_MS * 40000)
`define PEW_INIT_MS       10
`define PEW_INIT_CYC      (`PEW_INIT_MS * 40000)
`define PEW_CMD_ADDR_A    15'h5555
`define PEW_CMD_ADDR_B    15'h2aaa
`define PEW_CMD_DATA_A    8'haa
`define PEW_CMD_DATA_B    8'h55
`define PEW_CMD_LOCK      8'ha0
`define PEW_CMD_UNLOCK1   8'h80
`define PEW_CMD_UNLOCK2   8'h20
`endif

// ===== logic/pew_pkg.sv
package pew_pkg;
	typedef enum logic [1:0] {
		PEW_OP_READ,
		PEW_OP_WRITE,
		PEW_OP_LOCK,
		PEW_OP_UNLOCK
	} pew_op_t;
	typedef struct packed {
		pew_op_t     op;
		logic [14:0] byte_address;
		logic [7:0]  data;
		logic        last;
	} pew_req_t;
	typedef struct packed {
		logic       ok;
		logic [7:0] data;
	} pew_rsp_t;
endpackage : pew_pkg

// ===== logic/pew_host.sv
`timescale 1ns/10ps
`include "pew_defs.svh"
// What this block does
// - Write only with select, strobe low, gate high
// - Byte position from low address bits
// - Loads spaced 0.1 to 50 us
// - Strobe held high 100 us ends page
// - Locked device needs three-write prefix
// - Lock commands follow page timing
// - Six-write sequence clears the lock
module pew_host import pew_pkg::*; #(
	parameter int unsigned INIT_CYC   = `PEW_INIT_CYC,
	parameter int unsigned WINDOW_CYC = `PEW_WINDOW_CYC,
	parameter int unsigned WRITE_CYC  = `PEW_WRITE_CYC,
	parameter logic [14:0] CMD_ADDR_A = `PEW_CMD_ADDR_A,
	parameter logic [14:0] CMD_ADDR_B = `PEW_CMD_ADDR_B
) (
	input  wire logic        MCLK_I,
	input  wire logic        RST_I,
	input  wire logic        SUPPLY_GOOD_I,
	input  wire pew_req_t    REQ_I,
	input  wire logic        REQ_VALID_I,
	output logic             REQ_READY_O,
	output pew_rsp_t         RSP_O,
	output logic             RSP_VALID_O,
	output logic             LOCKED_O,
	output logic [14:0]      BYTE_ADDRESS_O,
	output logic [7:0]       DATA_BUS_O,
	output logic             DATA_BUS_OE_O,
	input  wire logic [7:0]  DATA_BUS_I,
	output logic             CHIP_SEL_N_O,
	output logic             OUT_GATE_N_O,
	output logic             WR_STROBE_N_O
);
	typedef enum logic [2:0] {
		ST_WAIT_POWER, ST_IDLE, ST_READ, ST_LOAD_LOW, ST_LOAD_HIGH, ST_PREFIX, ST_PROGRAM
	} pew_state_t;

	localparam int unsigned LOW_CYC  = `PEW_STROBE_LOW_CYC;
	localparam int unsigned READ_CYC = `PEW_READ_CYC;
	localparam int unsigned GAP_CYC  = `PEW_GAP_CYC;

	pew_state_t  state_ff;
	logic [31:0] cnt_ff;
	logic [2:0]  pre_idx_ff;
	logic [2:0]  pre_len_ff;
	pew_op_t     op_ff;
	logic [14:0] last_addr_ff;
	logic [7:0]  last_data_ff;
	logic        poll_prev_ff;
	logic        poll_first_ff;
	logic        last_ff;
	logic        locked_ff;
	logic        power_ok_ff;

	// Fixed command prefix entries, index 0..5
	function automatic logic [22:0] cmd_word(input logic [2:0] idx, input pew_op_t op);
		logic [7:0] third;
		third = (op == PEW_OP_UNLOCK) ? `PEW_CMD_UNLOCK1 : `PEW_CMD_LOCK;
		case (idx)
			3'h0: cmd_word = {CMD_ADDR_A, `PEW_CMD_DATA_A};
			3'h1: cmd_word = {CMD_ADDR_B, `PEW_CMD_DATA_B};
			3'h2: cmd_word = {CMD_ADDR_A, third};
			3'h3: cmd_word = {CMD_ADDR_A, `PEW_CMD_DATA_A};
			3'h4: cmd_word = {CMD_ADDR_B, `PEW_CMD_DATA_B};
			default: cmd_word = {CMD_ADDR_A, `PEW_CMD_UNLOCK2};
		endcase
	endfunction : cmd_word

	always_ff @(posedge MCLK_I) begin
		if (RST_I || !SUPPLY_GOOD_I) begin
			power_ok_ff <= 1'b0;
		end else if (state_ff == ST_WAIT_POWER && cnt_ff >= INIT_CYC - 1) begin
			power_ok_ff <= 1'b1;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			state_ff       <= ST_WAIT_POWER;
			cnt_ff         <= 32'h0;
			pre_idx_ff     <= 3'h0;
			pre_len_ff     <= 3'h0;
			op_ff          <= PEW_OP_READ;
			last_addr_ff   <= 15'h0;
			last_data_ff   <= 8'h0;
			poll_prev_ff   <= 1'b0;
			poll_first_ff  <= 1'b1;
			last_ff        <= 1'b0;
			locked_ff      <= 1'b0;
			REQ_READY_O    <= 1'b0;
			RSP_O          <= '0;
			RSP_VALID_O    <= 1'b0;
			BYTE_ADDRESS_O <= 15'h0;
			DATA_BUS_O     <= 8'h0;
			DATA_BUS_OE_O  <= 1'b0;
			CHIP_SEL_N_O   <= 1'b1;
			OUT_GATE_N_O   <= 1'b1;
			WR_STROBE_N_O  <= 1'b1;
		end else begin
			RSP_VALID_O <= 1'b0;
			REQ_READY_O <= 1'b0;
			cnt_ff      <= cnt_ff + 32'h1;
			case (state_ff)
				ST_WAIT_POWER: begin
					if (!SUPPLY_GOOD_I) begin
						cnt_ff <= 32'h0;
					end else if (power_ok_ff) begin
						state_ff    <= ST_IDLE;
						REQ_READY_O <= 1'b1;
					end
				end
				ST_IDLE: begin
					REQ_READY_O <= 1'b1;
					if (!SUPPLY_GOOD_I) begin
						REQ_READY_O <= 1'b0;
						state_ff    <= ST_WAIT_POWER;
						cnt_ff      <= 32'h0;
					end else if (REQ_VALID_I && REQ_READY_O) begin
						REQ_READY_O    <= 1'b0;
						op_ff          <= REQ_I.op;
						last_ff        <= REQ_I.last;
						cnt_ff         <= 32'h0;
						BYTE_ADDRESS_O <= REQ_I.byte_address;
						DATA_BUS_O     <= REQ_I.data;
						if (REQ_I.op == PEW_OP_READ) begin
							CHIP_SEL_N_O <= 1'b0;
							OUT_GATE_N_O <= 1'b0;
							state_ff     <= ST_READ;
						end else if (REQ_I.op == PEW_OP_WRITE && !locked_ff) begin
							state_ff <= ST_LOAD_LOW;
						end else begin
							pre_idx_ff <= 3'h0;
							last_addr_ff <= REQ_I.byte_address;
							last_data_ff <= REQ_I.data;
							pre_len_ff <= (REQ_I.op == PEW_OP_UNLOCK) ? 3'h6 : 3'h3;
							{BYTE_ADDRESS_O, DATA_BUS_O} <= cmd_word(3'h0, REQ_I.op);
							state_ff   <= ST_PREFIX;
						end
					end
				end
				ST_READ: begin
					if (cnt_ff >= READ_CYC) begin
						CHIP_SEL_N_O <= 1'b1;
						OUT_GATE_N_O <= 1'b1;
						RSP_VALID_O  <= 1'b1;
						RSP_O        <= '{ok: 1'b1, data: DATA_BUS_I};
						state_ff     <= ST_IDLE;
					end
				end
				ST_PREFIX, ST_LOAD_LOW: begin
					OUT_GATE_N_O  <= 1'b1;
					CHIP_SEL_N_O  <= 1'b0;
					DATA_BUS_OE_O <= 1'b1;
					WR_STROBE_N_O <= 1'b0;
					if (cnt_ff >= LOW_CYC) begin
						WR_STROBE_N_O <= 1'b1;
						CHIP_SEL_N_O  <= 1'b1;
						cnt_ff        <= 32'h0;
						if (state_ff == ST_PREFIX) begin
							pre_idx_ff <= pre_idx_ff + 3'h1;
							if (pre_idx_ff + 3'h1 == pre_len_ff) begin
								if (op_ff == PEW_OP_UNLOCK) locked_ff <= 1'b0;
								else locked_ff <= 1'b1;
							end
						end
						state_ff <= ST_LOAD_HIGH;
					end
				end
				ST_LOAD_HIGH: begin
					DATA_BUS_OE_O <= 1'b0;
					if (state_ff == ST_LOAD_HIGH && pre_idx_ff < pre_len_ff && op_ff != PEW_OP_READ
						&& cnt_ff >= GAP_CYC) begin
						{BYTE_ADDRESS_O, DATA_BUS_O} <= cmd_word(pre_idx_ff, op_ff);
						cnt_ff   <= 32'h0;
						state_ff <= ST_PREFIX;
					end else if (pre_idx_ff == pre_len_ff && pre_len_ff != 3'h0
						&& op_ff == PEW_OP_WRITE && cnt_ff >= GAP_CYC) begin
						pre_len_ff <= 3'h0;
						BYTE_ADDRESS_O <= last_addr_ff;
						DATA_BUS_O     <= last_data_ff;
						cnt_ff     <= 32'h0;
						state_ff   <= ST_LOAD_LOW;
					end else if (op_ff == PEW_OP_WRITE && !last_ff && pre_len_ff == 3'h0) begin
						REQ_READY_O <= (cnt_ff >= GAP_CYC - 1);
						if (REQ_VALID_I && REQ_READY_O && REQ_I.op == PEW_OP_WRITE) begin
							REQ_READY_O    <= 1'b0;
							BYTE_ADDRESS_O <= REQ_I.byte_address;
							DATA_BUS_O     <= REQ_I.data;
							last_ff        <= REQ_I.last;
							cnt_ff         <= 32'h0;
							state_ff       <= ST_LOAD_LOW;
						end else if (cnt_ff >= WINDOW_CYC / 2) begin
							REQ_READY_O <= 1'b0;
							last_ff     <= 1'b1;
						end
					end else if (cnt_ff >= WINDOW_CYC) begin
						last_addr_ff  <= BYTE_ADDRESS_O;
						last_data_ff  <= DATA_BUS_O;
						poll_first_ff <= 1'b1;
						pre_len_ff    <= 3'h0;
						cnt_ff        <= 32'h0;
						state_ff      <= ST_PROGRAM;
					end
				end
				ST_PROGRAM: begin
					// no loads; poll by toggle and inverted bit 7
					BYTE_ADDRESS_O <= last_addr_ff;
					if (cnt_ff[2:0] == 3'h0) begin
						CHIP_SEL_N_O <= 1'b0;
						OUT_GATE_N_O <= 1'b0;
					end else if (cnt_ff[2:0] == 3'(READ_CYC + 1)) begin
						CHIP_SEL_N_O  <= 1'b1;
						OUT_GATE_N_O  <= 1'b1;
						poll_prev_ff  <= DATA_BUS_I[6];
						poll_first_ff <= 1'b0;
						if ((!poll_first_ff && DATA_BUS_I[6] == poll_prev_ff
							&& DATA_BUS_I[7] == last_data_ff[7])
							|| cnt_ff >= WRITE_CYC) begin
							RSP_VALID_O <= 1'b1;
							RSP_O       <= '{ok: (cnt_ff < WRITE_CYC), data: DATA_BUS_I};
							state_ff    <= ST_IDLE;
						end
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			LOCKED_O <= 1'b0;
		end else begin
			LOCKED_O <= locked_ff;
		end
	end
endmodule : pew_host

// ===== bench/pew_host_props.sv
`timescale 1ns/10ps
module pew_host_props #(
	parameter int unsigned INIT_CYC   = 20,
	parameter int unsigned WINDOW_CYC = 40
) (
	input wire logic        MCLK_I,
	input wire logic        RST_I,
	input wire logic        SUPPLY_GOOD_I,
	input wire logic        REQ_READY_O,
	input wire logic [14:0] BYTE_ADDRESS_O,
	input wire logic [7:0]  DATA_BUS_O,
	input wire logic        DATA_BUS_OE_O,
	input wire logic        OUT_GATE_N_O,
	input wire logic        WR_STROBE_N_O
);
	int unsigned pwr_ff;
	int unsigned hi_ff;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (RST_I);
	// Cycles of good supply
	always_ff @(posedge MCLK_I) begin
		if (RST_I || !SUPPLY_GOOD_I) pwr_ff <= 0;
		else if (pwr_ff < INIT_CYC) pwr_ff <= pwr_ff + 1;
	end
	// Cycles of strobe high
	always_ff @(posedge MCLK_I) begin
		if (RST_I) hi_ff <= WINDOW_CYC;
		else if (!WR_STROBE_N_O) hi_ff <= 0;
		else if (hi_ff < WINDOW_CYC) hi_ff <= hi_ff + 1;
	end
	read_gate_a: assert property (!OUT_GATE_N_O |-> WR_STROBE_N_O && !DATA_BUS_OE_O)
		else $error("read gate");
	bus_turn_a: assert property (DATA_BUS_OE_O |-> OUT_GATE_N_O)
		else $error("bus fight");
	write_gate_a: assert property (!WR_STROBE_N_O |-> OUT_GATE_N_O && DATA_BUS_OE_O)
		else $error("write gate");
	strobe_width_a: assert property ($fell(WR_STROBE_N_O) |-> !WR_STROBE_N_O [*4])
		else $error("short strobe");
	addr_hold_a: assert property ($fell(WR_STROBE_N_O) |=> $stable(BYTE_ADDRESS_O) [*2])
		else $error("address hold");
	data_hold_a: assert property ($rose(WR_STROBE_N_O) |-> $stable(DATA_BUS_O))
		else $error("data hold");
	power_on_a: assert property (!WR_STROBE_N_O |-> pwr_ff >= INIT_CYC)
		else $error("early write");
	page_close_a: assert property (!OUT_GATE_N_O |-> hi_ff >= WINDOW_CYC)
		else $error("early poll");
	reset_idle_a: assert property (disable iff (1'b0) RST_I |=> WR_STROBE_N_O && !REQ_READY_O)
		else $error("reset idle");
endmodule : pew_host_props
bind pew_host pew_host_props #(.INIT_CYC(INIT_CYC), .WINDOW_CYC(WINDOW_CYC)) pew_host_props_inst (
	.MCLK_I, .RST_I, .SUPPLY_GOOD_I, .REQ_READY_O, .BYTE_ADDRESS_O, .DATA_BUS_O,
	.DATA_BUS_OE_O, .OUT_GATE_N_O, .WR_STROBE_N_O);

// ===== bench/pew_dev_model.sv
`timescale 1ns/10ps
module pew_dev_model #(
	parameter int          WIN_NS  = 800,
	parameter int          PROG_NS = 3000,
	parameter logic [14:0] CA      = 15'h5555,
	parameter logic [14:0] CB      = 15'h2aaa
) (
	input  wire logic        ce_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        we_n_i,
	input  wire logic [14:0] addr_i,
	input  wire logic [7:0]  data_i,
	output logic [7:0]       data_o
);
	logic [7:0]  mem [32768];
	logic [22:0] q [$];
	logic [22:0] lst;
	logic [14:0] a_ff;
	logic        busy = 1'b0;
	logic        lock = 1'b0;
	logic        tgl  = 1'b0;
	logic        pre;
	realtime     t_dn, t_up;
	wire logic   wr = !ce_n_i && !we_n_i && oe_n_i;
	initial begin
		data_o = 8'h00;
		foreach (mem[i]) mem[i] = 8'h00;
	end
	always @(posedge wr) begin
		a_ff = addr_i;
		t_dn = $realtime;
	end
	always @(negedge wr) if ($realtime - t_dn >= 20 && !busy) begin
		q.push_back({a_ff, data_i});
		lst = q[$];
		t_up = $realtime;
	end
	always #25 if (q.size() > 0 && we_n_i && $realtime - t_up >= WIN_NS) begin
		busy = 1'b1;
		pre = q.size() > 2 && q[0] == {CA, 8'haa} && q[1] == {CB, 8'h55};
		if (pre && q[2] == {CA, 8'ha0}) begin
			lock = 1'b1;
			q = q[3:$];
		end else if (pre && q.size() > 5 && q[2] == {CA, 8'h80}) begin
			lock = 1'b0;
			q = q[6:$];
		end else if (lock) q = {};
		// Command-only cycle echoes its last byte
		if (pre && q.size() == 0) mem[lst[22:8]] = lst[7:0];
		foreach (q[i]) mem[{lst[22:14], q[i][13:8]}] = q[i][7:0];
		q = {};
		#(PROG_NS);
		busy = 1'b0;
	end
	always @(negedge oe_n_i) if (busy) tgl = !tgl;
	always @(ce_n_i, oe_n_i, we_n_i, addr_i, busy, tgl)
		if (!ce_n_i && !oe_n_i && we_n_i)
			data_o = busy ? {~mem[lst[22:8]][7], tgl, 6'h15} : mem[addr_i];
		else data_o = ~data_o;
endmodule : pew_dev_model

// ===== bench/pew_host_tb_top.sv
`timescale 1ns/10ps
module pew_host_tb_top import pew_pkg::*;;
	localparam int INIT = 20;
	logic            clk = 1'b0;
	logic            rst = 1'b1;
	logic            sg  = 1'b1;
	logic            vld = 1'b0;
	logic            lk  = 1'b0;
	logic            rdy, rv, lkd, dboe, cs_n, oe_n, we_n;
	logic [14:0]     adr;
	logic [7:0]      dbo, dev;
	wire logic [7:0] dbi = dboe ? dbo : dev;
	pew_req_t        req = '0;
	pew_req_t        rows [16];
	pew_rsp_t        rsp, p;
	int              n_errors = 0;
	int              checks = 0;
	int              n;
	pew_host #(.INIT_CYC(INIT), .WINDOW_CYC(40), .WRITE_CYC(200)) pew_host_inst (
		.MCLK_I(clk), .RST_I(rst), .SUPPLY_GOOD_I(sg), .REQ_I(req), .REQ_VALID_I(vld),
		.REQ_READY_O(rdy), .RSP_O(rsp), .RSP_VALID_O(rv), .LOCKED_O(lkd), .BYTE_ADDRESS_O(adr),
		.DATA_BUS_O(dbo), .DATA_BUS_OE_O(dboe), .DATA_BUS_I(dbi), .CHIP_SEL_N_O(cs_n),
		.OUT_GATE_N_O(oe_n), .WR_STROBE_N_O(we_n));
	pew_dev_model pew_dev_model_inst (.ce_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n),
		.addr_i(adr), .data_i(dbo), .data_o(dev));
	task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic send(pew_req_t r);
		req <= r;
		vld <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		vld <= 1'b0;
		@(posedge clk);
	endtask : send
	task automatic get();
		do @(posedge clk); while (rv !== 1'b1);
		p = rsp;
	endtask : get
	task end_sim();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	initial forever #12.5 clk = ~clk;
	initial begin
		#750000;
		n_errors++;
		end_sim();
	end
	initial begin
		rows = '{'{PEW_OP_WRITE, 15'h0040, 8'ha5, 1'b1}, '{PEW_OP_READ, 15'h0040, 8'ha5, 1'b1},
			'{PEW_OP_WRITE, 15'h0040, 8'h5a, 1'b1}, '{PEW_OP_READ, 15'h0040, 8'h5a, 1'b1},
			'{PEW_OP_WRITE, 15'h0085, 8'h3c, 1'b0}, '{PEW_OP_WRITE, 15'h0081, 8'hc3, 1'b0},
			'{PEW_OP_WRITE, 15'h00bf, 8'h7e, 1'b1}, '{PEW_OP_READ, 15'h0081, 8'hc3, 1'b1},
			'{PEW_OP_READ, 15'h00bf, 8'h7e, 1'b1}, '{PEW_OP_READ, 15'h0082, 8'h00, 1'b1},
			'{PEW_OP_LOCK, 15'h0000, 8'h00, 1'b1}, '{PEW_OP_WRITE, 15'h0101, 8'h99, 1'b1},
			'{PEW_OP_READ, 15'h0101, 8'h99, 1'b1}, '{PEW_OP_UNLOCK, 15'h0000, 8'h00, 1'b1},
			'{PEW_OP_WRITE, 15'h0102, 8'h11, 1'b1}, '{PEW_OP_READ, 15'h0102, 8'h11, 1'b1}};
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			send(rows[i]);
			if (rows[i].last) begin
				get();
				if (rows[i].op == PEW_OP_READ) chk("rd", rows[i].data, p.data);
				else chk("ok", 8'h01, 8'(p.ok));
				if (rows[i].op == PEW_OP_WRITE) chk("poll", rows[i].data, p.data);
			end
			if (rows[i].op inside {PEW_OP_LOCK, PEW_OP_UNLOCK}) lk = rows[i].op == PEW_OP_LOCK;
			chk("locked", 8'(lk), 8'(lkd));
			$display("row %0d done", i);
		end
		for (int k = 0; k < 2; k++) begin
			if (k == 1) rst <= 1'b1;
			else sg <= 1'b0;
			repeat (16) @(posedge clk);
			chk("rdy_off", 8'h00, 8'(rdy));
			rst <= 1'b0;
			sg <= 1'b1;
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (rdy !== 1'b1 && n < 1000);
			chk("delay", 8'h01, 8'(n >= INIT && n <= INIT + 8));
			$display("power case %0d done", k);
		end
		send(rows[3]);
		get();
		chk("kept", 8'h5a, p.data);
		$display("retention case done");
		end_sim();
	end
endmodule : pew_host_tb_top
